// ===== rtcko_defines.svh
// Purpose: Offsets, field positions and reset values of the reload timer
// Assumes: Byte addresses on a 12-bit AXI4-Lite address
// Notes:   Definitions only
`ifndef RTCKO_DEFINES_SVH
`define RTCKO_DEFINES_SVH

// Printed register indices; byte address is four times the index
`define RTCKO_IDX_CTL        10'h0C8
`define RTCKO_IDX_MODE       10'h0C9
`define RTCKO_ADDR_CTL       ({`RTCKO_IDX_CTL, 2'b00})
`define RTCKO_ADDR_MODE      ({`RTCKO_IDX_MODE, 2'b00})
`define RTCKO_ADDR_CNT_LO    12'h328
`define RTCKO_ADDR_CNT_HI    12'h32C
`define RTCKO_ADDR_RLD_LO    12'h330
`define RTCKO_ADDR_RLD_HI    12'h334
`define RTCKO_ADDR_CTL_BIT   12'h338

// Control register fields
`define RTCKO_CTL_OVF        7
`define RTCKO_CTL_EXT        6
`define RTCKO_CTL_RXB        5
`define RTCKO_CTL_TXB        4
`define RTCKO_CTL_EXEN       3
`define RTCKO_CTL_RUN        2
`define RTCKO_CTL_CSEL       1
`define RTCKO_CTL_CPRL       0

// Mode register fields
`define RTCKO_MODE_OE        1
`define RTCKO_MODE_DOWN_COUNT_ENABLE      0

// Bit-access word fields
`define RTCKO_BIT_VAL        3

// Reset values
`define RTCKO_CTL_RST        8'h00
`define RTCKO_MODE_RST       2'h0
`define RTCKO_BYTE_RST       8'h00
`define RTCKO_BYTE_MAX       8'hFF

// Bus responses
`define RTCKO_RESP_OKAY      2'h0
`define RTCKO_RESP_SLVERR    2'h2

`endif

// ===== rtcko_pkg.sv
// Purpose: Types shared by the reload timer files
// Assumes: Nothing
// Notes:   Constants live in rtcko_defines.svh
package rtcko_pkg;
    typedef logic [1:0] rtcko_resp_t;
    typedef enum logic [1:0] {
        RTCKO_MODE_CAPTURE,
        RTCKO_MODE_RELOAD,
        RTCKO_MODE_BAUD
    } rtcko_mode_t;
endpackage

// ===== rtcko_pin_if.sv
// Purpose: Raw pin levels and their synchronised falling edges
// Assumes: Index 0 timer clock pin, index 1 external trigger pin
// Notes:   Shared by the timer core and its pin synchroniser
`timescale 1ns/1ps
`default_nettype none
interface rtcko_pin_if;
    logic [1:0] raw;
    logic [1:0] fall;
    modport sync (input raw, output fall);
    modport core (output raw, input fall);
endinterface
`default_nettype wire

// ===== rtcko_pin_sync.sv
// Purpose: Two-flop synchronisers and falling-edge detect for the pins
// Assumes: Pins idle high, so reset loads ones
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module rtcko_pin_sync (
    input  wire logic   clk,
    input  wire logic   rst,
    rtcko_pin_if.sync   pins
);
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_pin
            logic s1_reg;
            logic s2_reg;
            logic s3_reg;
            always_ff @(posedge clk) begin
                if (rst) begin
                    s1_reg <= 1'b1;
                    s2_reg <= 1'b1;
                    s3_reg <= 1'b1;
                end else begin
                    s1_reg <= pins.raw[g];
                    s2_reg <= s1_reg;
                    s3_reg <= s2_reg;
                end
            end
            assign pins.fall[g] = s3_reg & ~s2_reg;
        end
    endgenerate
endmodule
`default_nettype wire

// ===== rtcko_timer.sv
// Purpose: 16-bit reload timer with clock output, AXI4-Lite registers
// Assumes: CORE_CLK 25 MHz, synchronous active-high RESET
// Notes:   Pins are synchronised before use; outputs are registered
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "rtcko_defines.svh"

// Functional notes
// - Clock-out mode generates a 50 percent duty-cycle clock on the pin
// - In clock-out mode the low count byte advances at half core rate
// - Each clock-out overflow loads the reload pair except in capture mode; counting continues
// - Clock-out overflows raise no interrupt request
// - Output frequency is core clock over four times (65536 - reload) outside capture mode
// - Generated clock drives the timer clock pin
// - Counting only while run control is set
// - Baud generation and clock-out may run together on one reload pair
// - Overflow flag set only when both baud selects are zero; software clears
// - Trigger fall sets external flag; requests unless up/down enabled
// - Counter select picks core clock or, with output enable clear, timer pin falling edges
// - Output enable with counter select clear makes the timer pin a clock output
// - Down-count enable bit stored in mode register
// - Control register resets to zero and is bit addressable
// - Mode register low bits reset to zero, no bit access
// - Count held as two cascaded bytes, high advances on low carry
module rtcko_timer (
    input  wire logic          CORE_CLK,
    input  wire logic          RESET,
    input  wire logic [11:0]   S_AXI_AWADDR,
    input  wire logic          S_AXI_AWVALID,
    output logic               S_AXI_AWREADY,
    input  wire logic [31:0]   S_AXI_WDATA,
    input  wire logic [3:0]    S_AXI_WSTRB,
    input  wire logic          S_AXI_WVALID,
    output logic               S_AXI_WREADY,
    output rtcko_pkg::rtcko_resp_t S_AXI_BRESP,
    output logic               S_AXI_BVALID,
    input  wire logic          S_AXI_BREADY,
    input  wire logic [11:0]   S_AXI_ARADDR,
    input  wire logic          S_AXI_ARVALID,
    output logic               S_AXI_ARREADY,
    output logic [31:0]        S_AXI_RDATA,
    output rtcko_pkg::rtcko_resp_t S_AXI_RRESP,
    output logic               S_AXI_RVALID,
    input  wire logic          S_AXI_RREADY,
    input  wire logic          TIMER_CLOCK_PIN_I,
    output logic               TIMER_CLOCK_PIN_O,
    output logic               TIMER_CLOCK_PIN_OE,
    input  wire logic          EXTERNAL_TRIGGER_PIN_I,
    output logic               BAUD_TICK,
    output logic               TIMER_REQ
);
    import rtcko_pkg::*;

    function automatic logic is_baud(input logic [7:0] c);
        is_baud = c[`RTCKO_CTL_RXB] | c[`RTCKO_CTL_TXB];
    endfunction

    // Bus slave state
    logic [11:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0]  wstrb_reg;
    logic        aw_hold_reg;
    logic        w_hold_reg;
    logic        awready_reg;
    logic        wready_reg;
    logic        bvalid_reg;
    rtcko_resp_t bresp_reg;
    logic        arready_reg;
    logic        rvalid_reg;
    logic [31:0] rdata_reg;
    rtcko_resp_t rresp_reg;

    // Timer state
    logic [7:0]  ctl_reg;
    logic [7:0]  ctl_next;
    logic [1:0]  mode_reg;
    logic [7:0]  cnt_lo_reg;
    logic [7:0]  cnt_hi_reg;
    logic [7:0]  rld_lo_reg;
    logic [7:0]  rld_hi_reg;
    logic        pre_reg;
    logic        pin_o_reg;
    logic        pin_oe_reg;
    logic        baud_tick_reg;
    logic        req_reg;

    rtcko_pin_if pins ();

    assign pins.raw = {EXTERNAL_TRIGGER_PIN_I, TIMER_CLOCK_PIN_I};

    rtcko_pin_sync u_sync (
        .clk  (CORE_CLK),
        .rst  (RESET),
        .pins (pins.sync)
    );

    // Write decode
    wire wr_en    = aw_hold_reg & w_hold_reg & ~bvalid_reg;
    wire wr_lane  = wstrb_reg[0];
    wire hit_ctl  = awaddr_reg == `RTCKO_ADDR_CTL;
    wire hit_mode = awaddr_reg == `RTCKO_ADDR_MODE;
    wire hit_clo  = awaddr_reg == `RTCKO_ADDR_CNT_LO;
    wire hit_chi  = awaddr_reg == `RTCKO_ADDR_CNT_HI;
    wire hit_rlo  = awaddr_reg == `RTCKO_ADDR_RLD_LO;
    wire hit_rhi  = awaddr_reg == `RTCKO_ADDR_RLD_HI;
    wire hit_bit  = awaddr_reg == `RTCKO_ADDR_CTL_BIT;
    wire wr_hit   = hit_ctl | hit_mode | hit_clo | hit_chi | hit_rlo
                  | hit_rhi | hit_bit;
    wire wr_ctl   = wr_en & wr_lane & hit_ctl;
    wire wr_mode  = wr_en & wr_lane & hit_mode;
    wire wr_clo   = wr_en & wr_lane & hit_clo;
    wire wr_chi   = wr_en & wr_lane & hit_chi;
    wire wr_rlo   = wr_en & wr_lane & hit_rlo;
    wire wr_rhi   = wr_en & wr_lane & hit_rhi;
    wire wr_bit   = wr_en & wr_lane & hit_bit;
    wire cnt_wr   = wr_clo | wr_chi;
    wire [7:0] wbyte = wdata_reg[7:0];

    // Timer decode
    wire run      = ctl_reg[`RTCKO_CTL_RUN];
    wire csel     = ctl_reg[`RTCKO_CTL_CSEL];
    wire oe       = mode_reg[`RTCKO_MODE_OE];
    wire baud     = is_baud(ctl_reg);
    wire clkout   = oe & ~csel;
    rtcko_mode_t op_mode;
    assign op_mode = is_baud(ctl_reg) ? RTCKO_MODE_BAUD :
                     ctl_reg[`RTCKO_CTL_CPRL] ? RTCKO_MODE_CAPTURE :
                     RTCKO_MODE_RELOAD;
    wire int_tick = run & ~csel & pre_reg;
    wire ext_tick = run & csel & ~oe & pins.fall[0];
    wire tick     = int_tick | ext_tick;
    wire lo_carry = tick & (cnt_lo_reg == `RTCKO_BYTE_MAX);
    wire ovf      = lo_carry & (cnt_hi_reg == `RTCKO_BYTE_MAX);
    wire ext_ev   = ctl_reg[`RTCKO_CTL_EXEN] & pins.fall[1];
    wire reload_ev = (ovf & (op_mode != RTCKO_MODE_CAPTURE))
                   | (ext_ev & (op_mode == RTCKO_MODE_RELOAD));
    wire capture_ev = ext_ev & (op_mode == RTCKO_MODE_CAPTURE);
    wire [7:0] bit_mask = 8'h01 << wdata_reg[2:0];
    wire [7:0] ctl_sw = wr_ctl ? wbyte :
                        wr_bit ? (wdata_reg[`RTCKO_BIT_VAL] ?
                                  (ctl_reg | bit_mask) :
                                  (ctl_reg & ~bit_mask)) : ctl_reg;

    // Hardware sets win over a same-cycle software clear
    always_comb begin
        ctl_next = ctl_sw;
        if (ovf && !baud) begin
            ctl_next[`RTCKO_CTL_OVF] = 1'b1;
        end
        if (ext_ev) begin
            ctl_next[`RTCKO_CTL_EXT] = 1'b1;
        end
    end

    // Write channels
    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            aw_hold_reg <= 1'b0;
            awready_reg <= 1'b1;
            awaddr_reg  <= 12'h000;
        end else if (S_AXI_AWVALID && awready_reg) begin
            aw_hold_reg <= 1'b1;
            awready_reg <= 1'b0;
            awaddr_reg  <= S_AXI_AWADDR;
        end else if (bvalid_reg && S_AXI_BREADY) begin
            aw_hold_reg <= 1'b0;
            awready_reg <= 1'b1;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            w_hold_reg <= 1'b0;
            wready_reg <= 1'b1;
            wdata_reg  <= 32'h0000_0000;
            wstrb_reg  <= 4'h0;
        end else if (S_AXI_WVALID && wready_reg) begin
            w_hold_reg <= 1'b1;
            wready_reg <= 1'b0;
            wdata_reg  <= S_AXI_WDATA;
            wstrb_reg  <= S_AXI_WSTRB;
        end else if (bvalid_reg && S_AXI_BREADY) begin
            w_hold_reg <= 1'b0;
            wready_reg <= 1'b1;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= `RTCKO_RESP_OKAY;
        end else if (wr_en) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= wr_hit ? `RTCKO_RESP_OKAY : `RTCKO_RESP_SLVERR;
        end else if (S_AXI_BREADY) begin
            bvalid_reg <= 1'b0;
        end
    end

    // Read decode; reserved bits read as zero
    logic [31:0] rd_data;
    logic        rd_hit;
    always_comb begin
        rd_data = 32'h0000_0000;
        rd_hit  = 1'b1;
        if (S_AXI_ARADDR == `RTCKO_ADDR_CTL) begin
            rd_data[7:0] = ctl_reg;
        end else if (S_AXI_ARADDR == `RTCKO_ADDR_MODE) begin
            rd_data[1:0] = mode_reg;
        end else if (S_AXI_ARADDR == `RTCKO_ADDR_CNT_LO) begin
            rd_data[7:0] = cnt_lo_reg;
        end else if (S_AXI_ARADDR == `RTCKO_ADDR_CNT_HI) begin
            rd_data[7:0] = cnt_hi_reg;
        end else if (S_AXI_ARADDR == `RTCKO_ADDR_RLD_LO) begin
            rd_data[7:0] = rld_lo_reg;
        end else if (S_AXI_ARADDR == `RTCKO_ADDR_RLD_HI) begin
            rd_data[7:0] = rld_hi_reg;
        end else if (S_AXI_ARADDR == `RTCKO_ADDR_CTL_BIT) begin
            rd_data[7:0] = ctl_reg;
        end else begin
            rd_hit = 1'b0;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            arready_reg <= 1'b1;
            rvalid_reg  <= 1'b0;
            rdata_reg   <= 32'h0000_0000;
            rresp_reg   <= `RTCKO_RESP_OKAY;
        end else if (S_AXI_ARVALID && arready_reg) begin
            arready_reg <= 1'b0;
            rvalid_reg  <= 1'b1;
            rdata_reg   <= rd_data;
            rresp_reg   <= rd_hit ? `RTCKO_RESP_OKAY : `RTCKO_RESP_SLVERR;
        end else if (rvalid_reg && S_AXI_RREADY) begin
            arready_reg <= 1'b1;
            rvalid_reg  <= 1'b0;
        end
    end

    // Control and mode registers; reserved mode bits are not stored
    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            ctl_reg  <= `RTCKO_CTL_RST;
            mode_reg <= `RTCKO_MODE_RST;
        end else begin
            ctl_reg <= ctl_next;
            if (wr_mode) begin
                mode_reg <= wbyte[1:0];
            end
        end
    end

    // Internal rate is half the core clock, held in phase while stopped
    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            pre_reg <= 1'b0;
        end else begin
            pre_reg <= (run & ~csel) ? ~pre_reg : 1'b0;
        end
    end

    // Cascaded count bytes; software write wins over counting
    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            cnt_lo_reg <= `RTCKO_BYTE_RST;
            cnt_hi_reg <= `RTCKO_BYTE_RST;
        end else if (cnt_wr) begin
            if (wr_clo) begin
                cnt_lo_reg <= wbyte;
            end
            if (wr_chi) begin
                cnt_hi_reg <= wbyte;
            end
        end else if (reload_ev) begin
            cnt_lo_reg <= rld_lo_reg;
            cnt_hi_reg <= rld_hi_reg;
        end else if (tick) begin
            cnt_lo_reg <= cnt_lo_reg + 8'h01;
            cnt_hi_reg <= cnt_hi_reg + {7'h00, lo_carry};
        end
    end

    // Reload pair, shared by baud and clock-out rates
    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            rld_lo_reg <= `RTCKO_BYTE_RST;
            rld_hi_reg <= `RTCKO_BYTE_RST;
        end else begin
            if (wr_rlo) begin
                rld_lo_reg <= wbyte;
            end else if (capture_ev) begin
                rld_lo_reg <= cnt_lo_reg;
            end
            if (wr_rhi) begin
                rld_hi_reg <= wbyte;
            end else if (capture_ev) begin
                rld_hi_reg <= cnt_hi_reg;
            end
        end
    end

    // Pin toggles per overflow: two overflows per output period
    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            pin_o_reg     <= 1'b0;
            pin_oe_reg    <= 1'b0;
            baud_tick_reg <= 1'b0;
            req_reg       <= 1'b0;
        end else begin
            if (clkout && ovf) begin
                pin_o_reg <= ~pin_o_reg;
            end
            pin_oe_reg    <= oe;
            baud_tick_reg <= ovf & baud;
            req_reg       <= (ctl_reg[`RTCKO_CTL_OVF] & ~clkout)
                           | (ctl_reg[`RTCKO_CTL_EXT]
                              & ~mode_reg[`RTCKO_MODE_DOWN_COUNT_ENABLE]);
        end
    end

    assign S_AXI_AWREADY      = awready_reg;
    assign S_AXI_WREADY       = wready_reg;
    assign S_AXI_BVALID       = bvalid_reg;
    assign S_AXI_BRESP        = bresp_reg;
    assign S_AXI_ARREADY      = arready_reg;
    assign S_AXI_RVALID       = rvalid_reg;
    assign S_AXI_RDATA        = rdata_reg;
    assign S_AXI_RRESP        = rresp_reg;
    assign TIMER_CLOCK_PIN_O  = pin_o_reg;
    assign TIMER_CLOCK_PIN_OE = pin_oe_reg;
    assign BAUD_TICK          = baud_tick_reg;
    assign TIMER_REQ          = req_reg;

    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RESET);

    property p_clkout_toggle;
        clkout && ovf |=> TIMER_CLOCK_PIN_O != $past(TIMER_CLOCK_PIN_O);
    endproperty
    a_clkout_toggle: assert property (p_clkout_toggle)
        else $error("clock-out pin did not toggle on overflow");

    property p_half_rate;
        int_tick |=> !int_tick ##1 (int_tick || !(run && !csel));
    endproperty
    a_half_rate: assert property (p_half_rate)
        else $error("internal count rate is not half the core clock");

    property p_reload;
        ovf && !cnt_wr && op_mode != RTCKO_MODE_CAPTURE
            |=> {cnt_hi_reg, cnt_lo_reg} == $past({rld_hi_reg, rld_lo_reg});
    endproperty
    a_reload: assert property (p_reload)
        else $error("overflow did not load the reload pair");

    property p_no_req_clkout;
        clkout && !ctl_reg[`RTCKO_CTL_EXT] |=> !TIMER_REQ;
    endproperty
    a_no_req_clkout: assert property (p_no_req_clkout)
        else $error("clock-out overflow raised a request");

    property p_stopped;
        !run && !cnt_wr && !reload_ev
            |=> $stable({cnt_hi_reg, cnt_lo_reg});
    endproperty
    a_stopped: assert property (p_stopped)
        else $error("count moved while run control was clear");

    property p_ovf_flag;
        ovf && !baud |=> ctl_reg[`RTCKO_CTL_OVF];
    endproperty
    a_ovf_flag: assert property (p_ovf_flag)
        else $error("overflow flag not set");

    property p_ovf_baud;
        ovf && baud && !ctl_reg[`RTCKO_CTL_OVF] && !wr_ctl && !wr_bit
            |=> !ctl_reg[`RTCKO_CTL_OVF] && BAUD_TICK;
    endproperty
    a_ovf_baud: assert property (p_ovf_baud)
        else $error("baud overflow set the flag or gave no tick");

    property p_ext_flag;
        ext_ev |=> ctl_reg[`RTCKO_CTL_EXT];
    endproperty
    a_ext_flag: assert property (p_ext_flag)
        else $error("external flag not set by trigger fall");

    property p_ext_reload;
        ext_ev && !cnt_wr && op_mode == RTCKO_MODE_RELOAD
            |=> {cnt_hi_reg, cnt_lo_reg} == $past({rld_hi_reg, rld_lo_reg});
    endproperty
    a_ext_reload: assert property (p_ext_reload)
        else $error("trigger fall did not reload the count");

    property p_pin_count;
        run && csel && !oe && pins.fall[0] |-> tick && !int_tick;
    endproperty
    a_pin_count: assert property (p_pin_count)
        else $error("pin falling edge not counted");

    property p_oe;
        ##1 TIMER_CLOCK_PIN_OE == $past(mode_reg[`RTCKO_MODE_OE]);
    endproperty
    a_oe: assert property (p_oe)
        else $error("pin enable does not follow the output enable bit");
endmodule
`default_nettype wire

// ===== rtcko_pin_ext.sv
// Purpose: External circuitry on the timer clock and trigger pins
// Assumes: Both pins pulled up when nobody drives them
// Notes:   One-cycle strobes from the bench give four-cycle low pulses
`timescale 1ns/1ps
`default_nettype none
module rtcko_pin_ext (
    input  wire logic clk,
    input  wire logic pin_o,
    input  wire logic pin_oe,
    input  wire logic pulse_pin,
    input  wire logic pulse_trig,
    output logic      pin_i,
    output logic      trig_i
);
    logic [2:0] pin_low_reg  = 3'h0;
    logic [2:0] trig_low_reg = 3'h0;

    // Pulses outlast the two-flop synchroniser
    always_ff @(posedge clk) begin
        pin_low_reg  <= pulse_pin ? 3'h4 : pin_low_reg - 3'(pin_low_reg != 0);
        trig_low_reg <= pulse_trig ? 3'h4
                      : trig_low_reg - 3'(trig_low_reg != 0);
    end

    // Device drive wins; otherwise pull-up or external low pulse
    assign pin_i  = pin_oe ? pin_o : (pin_low_reg == 3'h0);
    assign trig_i = (trig_low_reg == 3'h0);
endmodule
`default_nettype wire

// ===== reload_timer_clock_out_test.sv
// Purpose: Self-checking bench of the reload timer
// Assumes: 25 MHz core clock, AXI4-Lite master in this bench
// Notes:   Reload values FFFE, then one with a random low byte from a fixed seed
`timescale 1ns/1ps
`default_nettype none
`include "rtcko_defines.svh"
module reload_timer_clock_out_test;
    import rtcko_pkg::*;
    logic        clk = 1'b0, rst = 1'b1;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0000_0000, rdata, rd_data;
    logic [3:0]  wstrb = 4'hF;
    logic        awready, wready, bvalid, arready, rvalid;
    rtcko_resp_t bresp, rresp, rd_resp, last_bresp;
    logic        pin_i, pin_o, pin_oe, trig_i, baud_tick, timer_req;
    logic        pulse_pin = 1'b0, pulse_trig = 1'b0;
    logic [15:0] r;
    logic [31:0] saved;
    int          g, failures = 0, check_count = 0;

    always #20 clk = ~clk;

    rtcko_timer DUT (.CORE_CLK(clk), .RESET(rst),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
        .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
        .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
        .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
        .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
        .TIMER_CLOCK_PIN_I(pin_i), .TIMER_CLOCK_PIN_O(pin_o),
        .TIMER_CLOCK_PIN_OE(pin_oe), .EXTERNAL_TRIGGER_PIN_I(trig_i),
        .BAUD_TICK(baud_tick), .TIMER_REQ(timer_req));

    rtcko_pin_ext ext (.clk(clk), .pin_o(pin_o), .pin_oe(pin_oe),
        .pulse_pin(pulse_pin), .pulse_trig(pulse_trig),
        .pin_i(pin_i), .trig_i(trig_i));

    task automatic final_report;
        if (failures == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Toggle or tick spacing in cycles of a half output period
    function automatic logic [31:0] half_gap(input logic [15:0] rv);
        return 32'h0002_0000 - {15'h0000, rv, 1'b0};
    endfunction

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic ta, tw, ha, hw;
        ta = 1'b0;
        tw = 1'b0;
        @(posedge clk);
        awaddr  <= a;
        wdata   <= {24'h00_0000, d};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        while (!(ta && tw)) begin
            @(negedge clk);
            ha = !ta && awready === 1'b1;
            hw = !tw && wready === 1'b1;
            @(posedge clk);
            if (ha) begin
                awvalid <= 1'b0;
                ta = 1'b1;
            end
            if (hw) begin
                wvalid <= 1'b0;
                tw = 1'b1;
            end
        end
        do begin
            @(negedge clk);
        end while (bvalid !== 1'b1);
        last_bresp = bresp;
        @(posedge clk);
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a);
        @(posedge clk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(negedge clk);
        end while (arready !== 1'b1);
        @(posedge clk);
        arvalid <= 1'b0;
        do begin
            @(negedge clk);
        end while (rvalid !== 1'b1);
        rd_data = rdata;
        rd_resp = rresp;
        @(posedge clk);
        rready <= 1'b0;
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [7:0] e);
        rd(a);
        check(rd_data, {24'h00_0000, e});
    endtask

    // First event syncs, second closes the measured spacing
    task automatic gap(input bit baud, output int gv);
        logic last;
        @(negedge clk);
        last = pin_o;
        for (int k = 0; k < 2; k++) begin
            gv = 0;
            do begin
                @(negedge clk);
                gv++;
            end while (!(baud ? baud_tick === 1'b1 : pin_o !== last)
                       && gv < 3000);
            last = pin_o;
        end
    endtask

    task automatic pulse(input bit trig);
        @(posedge clk);
        if (trig) pulse_trig <= 1'b1; else pulse_pin <= 1'b1;
        @(posedge clk);
        pulse_trig <= 1'b0;
        pulse_pin  <= 1'b0;
        repeat (10) @(posedge clk);
    endtask

    initial begin
        #(40 * 60000);
        failures++;
        final_report();
    end

    initial begin
        void'($urandom(32'h9784_a8a0));
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rdchk(`RTCKO_ADDR_CTL, 8'h00);
        rdchk(`RTCKO_ADDR_MODE, 8'h00);
        rdchk(12'h000, 8'h00);
        check(32'(rd_resp), 32'(`RTCKO_RESP_SLVERR));
        wr(12'h000, 8'hFF);
        check(32'(last_bresp), 32'(`RTCKO_RESP_SLVERR));
        for (int i = 0; i < 2; i++) begin
            r = (i == 0) ? 16'hFFFE : 16'hFF00 | 16'($urandom_range(0, 255));
            wr(`RTCKO_ADDR_MODE, 8'h02);
            wr(`RTCKO_ADDR_CTL, 8'h00);
            wr(`RTCKO_ADDR_RLD_LO, r[7:0]);
            wr(`RTCKO_ADDR_RLD_HI, r[15:8]);
            wr(`RTCKO_ADDR_CNT_LO, 8'hF0);
            wr(`RTCKO_ADDR_CNT_HI, 8'hFF);
            wr(`RTCKO_ADDR_CTL, 8'h04);
            gap(1'b0, g);
            check(32'(g), half_gap(r));
            gap(1'b0, g);
            check(32'(g), half_gap(r));
            check(32'(pin_oe), 32'h0000_0001);
            check(32'(timer_req), 32'h0000_0000);
            rdchk(`RTCKO_ADDR_CTL, 8'h84);
        end
        // Second clear: an overflow in the stopping cycle sets the flag again
        repeat (2) wr(`RTCKO_ADDR_CTL, 8'h00);
        rdchk(`RTCKO_ADDR_CTL, 8'h00);
        rd(`RTCKO_ADDR_CNT_LO);
        saved = rd_data;
        repeat (20) @(posedge clk);
        rd(`RTCKO_ADDR_CNT_LO);
        check(rd_data, saved);
        for (int k = 0; k < 2; k++) begin
            wr(`RTCKO_ADDR_CTL, k ? 8'h24 : 8'h14);
            gap(1'b1, g);
            check(32'(g), half_gap(r));
            gap(1'b0, g);
            check(32'(g), half_gap(r));
            rdchk(`RTCKO_ADDR_CTL, k ? 8'h24 : 8'h14);
        end
        wr(`RTCKO_ADDR_CTL, 8'h00);
        wr(`RTCKO_ADDR_MODE, 8'h00);
        @(negedge clk);
        check(32'(pin_oe), 32'h0000_0000);
        wr(`RTCKO_ADDR_CNT_LO, 8'hFF);
        wr(`RTCKO_ADDR_CNT_HI, 8'h00);
        wr(`RTCKO_ADDR_CTL, 8'h06);
        pulse(1'b0);
        wr(`RTCKO_ADDR_CTL, 8'h00);
        rdchk(`RTCKO_ADDR_CNT_LO, 8'h00);
        rdchk(`RTCKO_ADDR_CNT_HI, 8'h01);
        wr(`RTCKO_ADDR_CNT_LO, 8'h34);
        wr(`RTCKO_ADDR_CNT_HI, 8'h12);
        wr(`RTCKO_ADDR_RLD_LO, 8'hCD);
        wr(`RTCKO_ADDR_RLD_HI, 8'hAB);
        wr(`RTCKO_ADDR_CTL, 8'h08);
        pulse(1'b1);
        rdchk(`RTCKO_ADDR_CNT_LO, 8'hCD);
        rdchk(`RTCKO_ADDR_CNT_HI, 8'hAB);
        rdchk(`RTCKO_ADDR_CTL, 8'h48);
        check(32'(timer_req), 32'h0000_0001);
        wr(`RTCKO_ADDR_MODE, 8'h01);
        repeat (2) @(posedge clk);
        check(32'(timer_req), 32'h0000_0000);
        rdchk(`RTCKO_ADDR_MODE, 8'h01);
        wr(`RTCKO_ADDR_CTL_BIT, 8'h06);
        rdchk(`RTCKO_ADDR_CTL, 8'h08);
        wr(`RTCKO_ADDR_CTL_BIT, 8'h0A);
        rdchk(`RTCKO_ADDR_CTL, 8'h0C);
        // Capture select set: trigger fall copies count, no reload
        wr(`RTCKO_ADDR_CTL, 8'h09);
        wr(`RTCKO_ADDR_CNT_LO, 8'h56);
        wr(`RTCKO_ADDR_CNT_HI, 8'h78);
        pulse(1'b1);
        rdchk(`RTCKO_ADDR_RLD_LO, 8'h56);
        rdchk(`RTCKO_ADDR_RLD_HI, 8'h78);
        rdchk(`RTCKO_ADDR_CNT_HI, 8'h78);
        rdchk(`RTCKO_ADDR_CTL, 8'h49);
        final_report();
    end
endmodule
`default_nettype wire
